// File: rtl/weight_tare_zero_motion.sv
// Tare, gross/net, zero setting, drift tracking and motion logic per scale.
// Assumes converter samples and preset writes on core_clk; keys, scale
// select and setpoint-armed arrive as asynchronous pins. APB slave inside.
//
// Summary of operation
// [R1] Tare key stores current gross as auto tare and selects net view.
// [R2] Net weight is gross minus the tare in use.
// [R3] Mode picks tare: auto only, preset only; preset unwritable in auto.
// [R4] Combined mode uses auto plus preset tare in sum.
// [R5] Serial master writes preset tare for a chosen scale.
// [R6] With motion check on, tare is refused while motion flagged.
// [R7] Unipolar setting refuses tare at negative gross.
// [R8] Gross/net toggle affects only the selected scale.
// [R9] Net view is refused while tare in use is zero.
// [R10] Accepted zero makes gross zero and clears auto tare.
// [R11] Zero needs no motion and total correction within -1% to +3% capacity.
// [R12] Good-zero flag when shown weight is under a quarter resolution.
// [R13] Tracking and rezero inhibited by armed setpoint or out-of-band zero.
// [R14] Tracking needs mode, gross good zero, no motion, rate under limit.
// [R15] Rate limit is per minute in resolution steps, so rescales.
// [R16] Rezero needs combined mode, negative gross, gross view, 5 s stable.
// [R17] Motion when change over max(update, 200 ms) exceeds the window.
// [R18] Motion flag held for settle time after weight becomes stable.
// [R19] With motion check on, printout waits until motion clears.
// [R20] Refused commands change nothing; each scale decides on its own.
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/10ps
module weight_tare_zero_motion
  import weigh_pkg::*;
#(
  parameter int MS_CYC = MS_CYC_DEF
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Converter and serial master
  input wire sample_s sample,
  input wire preset_wr_s preset_wr,
  // Operator pins
  input wire keys_s keys,
  input wire logic [SCALE_IDX_W-1:0] sel_scale,
  input wire logic setpoint_armed,
  // Results
  output logic [WW-1:0] shown_weight,
  output logic [NUM_SCALES-1:0] motion,
  output logic [NUM_SCALES-1:0] good_zero,
  output logic [NUM_SCALES-1:0] net_shown,
  output logic print_strobe,
  output logic [SCALE_IDX_W-1:0] print_scale
);

  function automatic logic [WW:0] abs_w(input logic signed [WW:0] v);
    abs_w = v[WW] ? -v : v;
  endfunction : abs_w

  // Configuration registers
  logic [5:0] ctrl;
  logic [WW-1:0] capacity;
  logic [WW-1:0] resolution;
  logic [WW-1:0] motion_win;
  logic [15:0] settle_ms;
  logic [15:0] update_ms;
  logic [15:0] drift_rate;

  wire tare_mode_e tare_mode = tare_mode_e'(ctrl[CTRL_TARE_LSB +: 2]);
  wire drift_mode_e drift_mode = drift_mode_e'(ctrl[CTRL_DRIFT_LSB +: 2]);
  wire logic motion_check = ctrl[CTRL_MCHECK];
  wire logic unipolar = ctrl[CTRL_UNIPOLAR];

  // Pin synchronisers
  logic [3:0] keys_s1;
  logic [3:0] keys_s2;
  logic [3:0] keys_prev;
  logic [SCALE_IDX_W-1:0] sel_s1;
  logic [SCALE_IDX_W-1:0] sel_s2;
  logic armed_s1;
  logic armed_s2;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      keys_s1 <= 4'h0;
      keys_s2 <= 4'h0;
      keys_prev <= 4'h0;
      sel_s1 <= '0;
      sel_s2 <= '0;
      armed_s1 <= 1'b0;
      armed_s2 <= 1'b0;
    end else begin
      keys_s1 <= keys;
      keys_s2 <= keys_s1;
      keys_prev <= keys_s2;
      sel_s1 <= sel_scale;
      sel_s2 <= sel_s1;
      armed_s1 <= setpoint_armed;
      armed_s2 <= armed_s1;
    end
  end

  wire logic [3:0] key_hit = keys_s2 & ~keys_prev;
  wire logic tare_key = key_hit[3];
  wire logic zero_key = key_hit[2];
  wire logic gn_key = key_hit[1];
  wire logic print_key = key_hit[0];

  // Millisecond tick and measurement period
  logic [$clog2(MS_CYC)-1:0] ms_div;
  logic ms_tick;
  logic [15:0] period_ms_cnt;
  wire logic [15:0] period_ms = (update_ms > MOTION_MIN_MS) ? update_ms : MOTION_MIN_MS; // [R17]
  wire logic period_end = ms_tick && (period_ms_cnt >= period_ms - 16'd1);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ms_div <= '0;
      ms_tick <= 1'b0;
      period_ms_cnt <= 16'h0000;
    end else begin
      ms_tick <= (ms_div == $bits(ms_div)'(MS_CYC - 1));
      ms_div <= (ms_div == $bits(ms_div)'(MS_CYC - 1)) ? '0 : ms_div + 1'b1;
      if (period_end) period_ms_cnt <= 16'h0000;
      else if (ms_tick) period_ms_cnt <= period_ms_cnt + 16'd1;
    end
  end

  // Zero band limits
  wire logic signed [WW:0] band_lo = -$signed({1'b0, capacity / 24'd100}); // [R11]
  wire logic signed [WW:0] band_hi = $signed({1'b0, (capacity / 24'd100) * 24'd3});
  // Allowed change per period scaled from per-minute steps
  wire logic [63:0] rate_lim = 64'(drift_rate) * 64'(resolution) * 64'(period_ms); // [R15]

  // APB write decode
  wire logic apb_wr = psel && penable && pwrite && pready;
  wire logic [7:0] a8 = paddr[7:0];
  wire logic scale_area = (a8 >= OFS_SCALE_BASE) &&
                          (a8 < OFS_SCALE_BASE + 8'(NUM_SCALES) * OFS_SCALE_STRIDE);
  wire logic [7:0] scale_rel = a8 - OFS_SCALE_BASE;
  wire logic [SCALE_IDX_W-1:0] apb_scale = scale_rel[4 +: SCALE_IDX_W];
  wire logic [3:0] apb_sub = scale_rel[3:0];

  logic [NUM_SCALES-1:0][WW-1:0] gross_q;
  logic [NUM_SCALES-1:0][WW-1:0] net_q;
  logic [NUM_SCALES-1:0][WW-1:0] zero_q;
  logic [NUM_SCALES-1:0][WW-1:0] preset_q;
  logic [NUM_SCALES-1:0][WW-1:0] shown_q;
  logic [NUM_SCALES-1:0] motion_q;
  logic [NUM_SCALES-1:0] net_view_q;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SCALES; gi++) begin : g_scale
      logic signed [WW-1:0] raw_q;
      logic signed [WW-1:0] zero_off;
      logic signed [WW-1:0] auto_tare;
      logic signed [WW-1:0] preset_tare;
      logic signed [WW-1:0] prev_gross;
      logic show_net;
      logic moved;
      logic [15:0] hold_cnt;
      logic [15:0] stable_cnt;

      wire logic is_sel = (sel_s2 == SCALE_IDX_W'(gi));
      wire logic signed [WW-1:0] gross = WW'(raw_q - zero_off);
      wire logic signed [WW-1:0] tare_use =
        (tare_mode == TARE_PRESET) ? preset_tare :
        (tare_mode == TARE_SUM) ? WW'(auto_tare + preset_tare) : auto_tare; // [R3] [R4]
      wire logic signed [WW-1:0] net = WW'(gross - tare_use); // [R2]
      wire logic net_ok = (tare_use != '0); // [R9]
      wire logic net_eff = show_net && net_ok;
      wire logic signed [WW-1:0] pres = net_eff ? net : gross;
      wire logic [WW+2:0] pres_x4 = {abs_w(WW'(pres)), 2'b00};
      wire logic [WW+2:0] gross_x4 = {abs_w(WW'(gross)), 2'b00};
      wire logic gz_pres = pres_x4 < (WW+3)'(resolution); // [R12]
      wire logic gz_gross = gross_x4 < (WW+3)'(resolution);
      wire logic signed [WW:0] new_zero = (WW+1)'(zero_off) + (WW+1)'(gross);
      wire logic band_ok = (new_zero >= band_lo) && (new_zero <= band_hi);
      wire logic [WW:0] delta = abs_w((WW+1)'(gross) - (WW+1)'(prev_gross));
      wire logic rate_ok = 64'(delta) * 64'(MS_PER_MIN) < rate_lim;
      wire logic gross_neg = gross[WW-1];

      wire logic tare_ok = tare_key && is_sel && !(motion_check && motion_q[gi]) // [R6]
                           && !(unipolar && gross_neg); // [R7] [R20]
      wire logic zero_ok = zero_key && is_sel && !motion_q[gi] && band_ok; // [R11] [R20]
      wire logic common_ok = !armed_s2 && band_ok; // [R13]
      wire logic track_ok = period_end && common_ok && gz_gross && !motion_q[gi] && rate_ok &&
                            (drift_mode == DRIFT_ON ||
                             drift_mode == DRIFT_PLUS_NEGATIVE_REZERO); // [R14]
      wire logic rezero_ok = period_end && common_ok && gross_neg && !net_eff &&
                             drift_mode == DRIFT_PLUS_NEGATIVE_REZERO &&
                             stable_cnt == AUTOZERO_STABLE_MS; // [R16]
      wire logic preset_apb = apb_wr && scale_area && apb_scale == SCALE_IDX_W'(gi) &&
                              apb_sub == SUB_PRESET;
      wire logic preset_ser = preset_wr.valid && preset_wr.scale == SCALE_IDX_W'(gi); // [R5]

      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          raw_q <= '0;
          zero_off <= '0;
          auto_tare <= '0;
          preset_tare <= '0;
          show_net <= 1'b0;
        end else begin
          if (sample.valid) raw_q <= sample.raw[gi];
          if (zero_ok || track_ok || rezero_ok) zero_off <= WW'(new_zero); // [R10] [R14] [R16]
          if (zero_ok) auto_tare <= '0; // [R10]
          else if (tare_ok) auto_tare <= gross; // [R1]
          // Auto mode locks the preset; serial write wins over APB
          if (tare_mode != TARE_AUTO) begin
            if (preset_ser) preset_tare <= preset_wr.value; // [R3] [R5]
            else if (preset_apb) preset_tare <= pwdata[WW-1:0];
          end
          if (tare_ok) show_net <= 1'b1; // [R1]
          else if (!net_ok || (gn_key && is_sel)) show_net <= !net_eff && net_ok; // [R8] [R9]
        end
      end

      // Motion detection with settle hold
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          prev_gross <= '0;
          moved <= 1'b0;
          hold_cnt <= 16'h0000;
          stable_cnt <= 16'h0000;
          motion_q[gi] <= 1'b0;
        end else begin
          if (period_end) begin
            prev_gross <= gross;
            moved <= delta > (WW+1)'(motion_win); // [R17]
          end
          if (moved) hold_cnt <= settle_ms; // [R18]
          else if (ms_tick && hold_cnt != 16'h0000) hold_cnt <= hold_cnt - 16'd1;
          motion_q[gi] <= moved || hold_cnt != 16'h0000; // [R18]
          if (motion_q[gi]) stable_cnt <= 16'h0000;
          else if (ms_tick && stable_cnt != AUTOZERO_STABLE_MS) stable_cnt <= stable_cnt + 16'd1;
        end
      end

      assign gross_q[gi] = gross;
      assign net_q[gi] = net;
      assign zero_q[gi] = zero_off;
      assign preset_q[gi] = preset_tare;
      assign shown_q[gi] = pres;
      assign net_view_q[gi] = net_eff;

      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          good_zero[gi] <= 1'b0;
          net_shown[gi] <= 1'b0;
        end else begin
          good_zero[gi] <= gz_pres; // [R12]
          net_shown[gi] <= net_eff;
        end
      end
    end
  endgenerate

  assign motion = motion_q;

  // Printout waits for stable weight when motion check is on
  logic print_pend;
  logic [SCALE_IDX_W-1:0] print_sel;
  wire logic print_go = print_pend && !(motion_check && motion_q[print_sel]); // [R19]

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      print_pend <= 1'b0;
      print_sel <= '0;
      print_strobe <= 1'b0;
      print_scale <= '0;
      shown_weight <= '0;
    end else begin
      print_strobe <= print_go;
      if (print_go) print_scale <= print_sel;
      // A new request during a wait retargets the pending one
      if (print_key) begin
        print_pend <= 1'b1;
        print_sel <= sel_s2;
      end else if (print_go) begin
        print_pend <= 1'b0;
      end
      shown_weight <= shown_q[sel_s2];
    end
  end

  // APB register file
  wire logic global_hit = (a8 <= OFS_STATUS) && (a8[1:0] == 2'b00);
  wire logic addr_ok = (global_hit || scale_area) && paddr[31:8] == 24'h000000;
  wire logic [31:0] status_word = 32'({net_view_q, 6'(0), good_zero, 6'(0), motion_q});
  logic [31:0] scale_rd;
  logic [31:0] global_rd;

  always_comb begin
    unique case (apb_sub)
      SUB_PRESET: scale_rd = 32'(preset_q[apb_scale]);
      SUB_NET: scale_rd = 32'(net_q[apb_scale]);
      SUB_GROSS: scale_rd = 32'(gross_q[apb_scale]);
      SUB_ZERO: scale_rd = 32'(zero_q[apb_scale]);
      default: scale_rd = 32'h00000000;
    endcase
    unique case (a8)
      OFS_CTRL: global_rd = 32'(ctrl);
      OFS_CAPACITY: global_rd = 32'(capacity);
      OFS_RESOLUTION: global_rd = 32'(resolution);
      OFS_MOTION_WIN: global_rd = 32'(motion_win);
      OFS_SETTLE_MS: global_rd = 32'(settle_ms);
      OFS_UPDATE_MS: global_rd = 32'(update_ms);
      OFS_DRIFT_RATE: global_rd = 32'(drift_rate);
      OFS_STATUS: global_rd = status_word;
      default: global_rd = 32'h00000000;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      ctrl <= CTRL_RST;
      capacity <= CAPACITY_RST;
      resolution <= RESOLUTION_RST;
      motion_win <= MOTION_WIN_RST;
      settle_ms <= SETTLE_MS_RST;
      update_ms <= UPDATE_MS_RST;
      drift_rate <= DRIFT_RATE_RST;
    end else begin
      // One wait state keeps the read mux off the bus path
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !addr_ok;
      if (psel && penable && !pready && !pwrite)
        prdata <= !addr_ok ? 32'h00000000 : (scale_area ? scale_rd : global_rd);
      if (apb_wr && addr_ok && !scale_area) begin
        unique case (a8)
          OFS_CTRL: ctrl <= pwdata[5:0];
          OFS_CAPACITY: capacity <= pwdata[WW-1:0];
          OFS_RESOLUTION: resolution <= pwdata[WW-1:0];
          OFS_MOTION_WIN: motion_win <= pwdata[WW-1:0];
          OFS_SETTLE_MS: settle_ms <= pwdata[15:0];
          OFS_UPDATE_MS: update_ms <= pwdata[15:0];
          OFS_DRIFT_RATE: drift_rate <= pwdata[15:0];
          default: ;
        endcase
      end
    end
  end
endmodule : weight_tare_zero_motion

// File: inc/weigh_pkg.sv
// Constants, register map and carriers for the scale weight processing block.
// Assumes one 10 MHz core clock and synchronised weighing channels.
package weigh_pkg;
  localparam int NUM_SCALES = 2;
  localparam int WW = 24;
  localparam int SCALE_IDX_W = 1;
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int MS_NS = 1000000;
  localparam int MS_CYC_DEF = MS_NS / CLK_PERIOD_NS;
  localparam logic [15:0] MOTION_MIN_MS = 16'd200;
  localparam int AUTOZERO_STABLE_S = 5;
  localparam logic [15:0] AUTOZERO_STABLE_MS = 16'(AUTOZERO_STABLE_S * 1000);
  localparam longint MS_PER_MIN = 60000;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CAPACITY = 8'h04;
  localparam logic [7:0] OFS_RESOLUTION = 8'h08;
  localparam logic [7:0] OFS_MOTION_WIN = 8'h0c;
  localparam logic [7:0] OFS_SETTLE_MS = 8'h10;
  localparam logic [7:0] OFS_UPDATE_MS = 8'h14;
  localparam logic [7:0] OFS_DRIFT_RATE = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_SCALE_BASE = 8'h20;
  localparam logic [7:0] OFS_SCALE_STRIDE = 8'h10;
  localparam logic [3:0] SUB_PRESET = 4'h0;
  localparam logic [3:0] SUB_NET = 4'h4;
  localparam logic [3:0] SUB_GROSS = 4'h8;
  localparam logic [3:0] SUB_ZERO = 4'hc;
  // Control and status fields
  localparam int CTRL_TARE_LSB = 0;
  localparam int CTRL_MCHECK = 2;
  localparam int CTRL_UNIPOLAR = 3;
  localparam int CTRL_DRIFT_LSB = 4;
  localparam int STAT_GZ_LSB = 8;
  localparam int STAT_NET_LSB = 16;
  // Reset values
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [WW-1:0] CAPACITY_RST = 24'h002710;
  localparam logic [WW-1:0] RESOLUTION_RST = 24'h000001;
  localparam logic [WW-1:0] MOTION_WIN_RST = 24'h000002;
  localparam logic [15:0] SETTLE_MS_RST = 16'h01f4;
  localparam logic [15:0] UPDATE_MS_RST = 16'h00c8;
  localparam logic [15:0] DRIFT_RATE_RST = 16'h0002;

  typedef enum logic [1:0] {
    TARE_AUTO = 2'b00,
    TARE_PRESET = 2'b01,
    TARE_SUM = 2'b10
  } tare_mode_e;

  typedef enum logic [1:0] {
    DRIFT_OFF = 2'b00,
    DRIFT_ON = 2'b01,
    DRIFT_PLUS_NEGATIVE_REZERO = 2'b10
  } drift_mode_e;

  typedef struct packed {
    logic valid;
    logic [NUM_SCALES-1:0][WW-1:0] raw;
  } sample_s;

  typedef struct packed {
    logic valid;
    logic [SCALE_IDX_W-1:0] scale;
    logic [WW-1:0] value;
  } preset_wr_s;

  typedef struct packed {
    logic tare;
    logic zero;
    logic gross_net;
    logic print;
  } keys_s;
endpackage : weigh_pkg

// File: sim/weight_tare_zero_motion_checker.sv
// Port-level assertions for the weighing block.
// Assumes the APB master holds psel and penable until pready.
`timescale 1ns/10ps
module weight_tare_zero_motion_checker
  import weigh_pkg::*;
#(
  parameter int MS_CYC = MS_CYC_DEF
) (
  // Clock, reset and bus
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Operator side and results
  input wire keys_s keys,
  input wire logic [WW-1:0] shown_weight,
  input wire logic [NUM_SCALES-1:0] motion,
  input wire logic [NUM_SCALES-1:0] net_shown,
  input wire logic print_strobe,
  input wire logic [SCALE_IDX_W-1:0] print_scale
);
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic check_on;
  logic [3:0] key_age;
  // Motion check bit as last written
  wire ctrl_wr = psel && penable && pready && pwrite && paddr == 32'(OFS_CTRL);
  wire [3:0] next_key_age = (|keys) ? 4'h0 : key_age + 4'(key_age != 4'hf);
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      check_on <= 1'b0;
      key_age <= 4'hf;
    end else begin
      check_on <= ctrl_wr ? pwdata[CTRL_MCHECK] : check_on;
      key_age <= next_key_age;
    end
  end
  apb_answer_a: assert property (psel && penable && !pready |=> pready)
    else $error("late pready");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("long pready");
  ready_req_a: assert property (pready |-> psel && penable)
    else $error("stray pready");
  err_range_a: assert property (pready && paddr[31:6] != 0 |-> pslverr && (pwrite || prdata == 0))
    else $error("unmapped not refused");
  err_mapped_a: assert property (pready && paddr < 32'h40 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped refused");
  print_pulse_a: assert property (print_strobe |=> !print_strobe)
    else $error("long print strobe");
  print_still_a: assert property (print_strobe && check_on |-> !motion[print_scale])
    else $error("print in motion");
  print_cause_a: assert property (print_strobe && !check_on |-> key_age < 4'h8)
    else $error("print without key");
  motion_hold_a: assert property ($rose(motion[0]) |-> motion[0] [*8])
    else $error("motion dropped early");
  net_cause_a: assert property ($rose(net_shown[0]) || $rose(net_shown[1]) |-> key_age < 4'h8)
    else $error("net view without key");
  reset_clear_a: assert property ($rose(reset_n) |-> net_shown == '0 && !print_strobe && shown_weight == '0)
    else $error("outputs set after reset");
  net_c: cover property ($rose(net_shown[0]));
  held_print_c: cover property (print_strobe && check_on);
  motion_c: cover property ($rose(motion[0]));
  refuse_c: cover property (pready && pslverr);
endmodule : weight_tare_zero_motion_checker

bind weight_tare_zero_motion weight_tare_zero_motion_checker #(.MS_CYC(MS_CYC)) chk (
  .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .keys(keys), .shown_weight(shown_weight), .motion(motion), .net_shown(net_shown),
  .print_strobe(print_strobe), .print_scale(print_scale)
);

// File: sim/scale_feed_model.sv
// Converter and serial master in front of the weighing block.
// Assumes the testbench sets platform loads and calls send_preset.
`timescale 1ns/10ps
module scale_feed_model
  import weigh_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Loads on the platforms
  input wire logic [NUM_SCALES-1:0][WW-1:0] load,
  // Towards the block
  output sample_s sample,
  output preset_wr_s preset_wr
);
  logic [7:0] tick;
  // Raw lines toggle between samples so a stale value is never mistaken
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick <= 8'h00;
      sample <= '0;
    end else begin
      tick <= (tick == 8'h13) ? 8'h00 : tick + 8'h01;
      sample.valid <= (tick == 8'h13);
      sample.raw <= (tick == 8'h13) ? load : ~sample.raw;
    end
  end
  initial preset_wr = '0;
  task automatic send_preset(input logic [SCALE_IDX_W-1:0] s, input logic [WW-1:0] v);
    @(posedge core_clk);
    preset_wr <= '{valid: 1'b1, scale: s, value: v};
    @(posedge core_clk);
    preset_wr <= '{valid: 1'b0, scale: ~s, value: ~v};
  endtask : send_preset
endmodule : scale_feed_model

// File: sim/weight_tare_zero_motion_tb.sv
// Self-checking testbench for the weighing block.
// Assumes a shortened millisecond tick of 10 cycles.
`timescale 1ns/10ps
module weight_tare_zero_motion_tb
  import weigh_pkg::*;
;
  localparam int K_PRINT = 0, K_GN = 1, K_ZERO = 2, K_TARE = 3;
  logic core_clk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic setpoint_armed, print_strobe;
  logic [31:0] paddr, pwdata, prdata;
  logic [SCALE_IDX_W-1:0] sel_scale, print_scale;
  logic [WW-1:0] shown_weight;
  logic [NUM_SCALES-1:0] motion, good_zero, net_shown;
  logic [NUM_SCALES-1:0][WW-1:0] wgt;
  sample_s sample;
  preset_wr_s preset_wr;
  keys_s keys;
  int errors = 0;
  int total_checks = 0;
  weight_tare_zero_motion #(.MS_CYC(10)) dut (
    .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample(sample), .preset_wr(preset_wr), .keys(keys), .sel_scale(sel_scale),
    .setpoint_armed(setpoint_armed), .shown_weight(shown_weight), .motion(motion),
    .good_zero(good_zero), .net_shown(net_shown), .print_strobe(print_strobe),
    .print_scale(print_scale)
  );
  scale_feed_model feed (
    .core_clk(core_clk), .reset_n(reset_n), .load(wgt), .sample(sample), .preset_wr(preset_wr)
  );
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  function automatic logic [31:0] w(input int v);
    return {8'h00, 24'(v)};
  endfunction : w
  function automatic logic [31:0] sreg(input int s, input logic [3:0] sub);
    return 32'(OFS_SCALE_BASE) + 32'(OFS_SCALE_STRIDE) * 32'(s) + 32'(sub);
  endfunction : sreg
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic apb(input logic [31:0] a, input logic wr, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) errors++;
  endtask : apb
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(a, 1'b1, d, r, e);
  endtask : wr
  task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(a, 1'b0, 32'h0, r, e);
    check(what, r, exp);
  endtask : rd_chk
  task automatic press(input int k, input int s);
    sel_scale <= SCALE_IDX_W'(s);
    keys <= keys_s'(4'h1 << k);
    repeat (6) @(posedge core_clk);
    keys <= '0;
    repeat (6) @(posedge core_clk);
  endtask : press
  task automatic put(input int s, input int v);
    wgt[s] <= 24'(v);
    repeat (60) @(posedge core_clk);
  endtask : put
  // One motion period, then until the hold runs out
  task automatic settle(input int s, input int v);
    int n = 0;
    put(s, v);
    repeat (2100) @(posedge core_clk);
    while (motion[s] !== 1'b0 && n < 6000) begin
      @(posedge core_clk);
      n++;
    end
  endtask : settle
  task automatic wait_sig(input int s, input bit strobe);
    int n = 0;
    while ((strobe ? print_strobe : motion[s]) !== 1'b1 && n < 8000) begin
      @(posedge core_clk);
      n++;
    end
  endtask : wait_sig
  task automatic t_regs();
    logic [31:0] r;
    logic e;
    rd_chk("ctrl", 32'(OFS_CTRL), 32'(CTRL_RST));
    rd_chk("capacity", 32'(OFS_CAPACITY), 32'(CAPACITY_RST));
    rd_chk("settle", 32'(OFS_SETTLE_MS), 32'(SETTLE_MS_RST));
    apb(32'h0000_0140, 1'b0, 32'h0, r, e);
    check("unmapped err", 32'(e), 32'h1);
    check("unmapped data", r, 32'h0);
    wr(32'(OFS_SETTLE_MS), 32'h0000_000a);
  endtask : t_regs
  task automatic t_tare();
    settle(0, 100);
    press(K_GN, 0);
    check("net refused", 32'(net_shown), 32'h0);
    press(K_TARE, 0);
    check("tare net", 32'(net_shown), 32'h1);
    put(0, 130);
    check("net shown", 32'(shown_weight), w(30));
    press(K_GN, 1);
    check("other scale", 32'(net_shown), 32'h1);
    press(K_GN, 0);
    check("gross view", 32'(shown_weight), w(130));
    press(K_GN, 0);
    check("net again", 32'(net_shown), 32'h1);
  endtask : t_tare
  task automatic t_preset();
    feed.send_preset(0, 24'd40);
    rd_chk("preset locked", sreg(0, SUB_PRESET), 32'h0);
    wr(32'(OFS_CTRL), 32'h1);
    feed.send_preset(0, 24'd40);
    feed.send_preset(1, 24'd7);
    rd_chk("preset one", sreg(1, SUB_PRESET), w(7));
    rd_chk("preset net", sreg(0, SUB_NET), w(90));
    wr(32'(OFS_CTRL), 32'h2);
    settle(0, 0);
    press(K_TARE, 0);
    check("sum tare", 32'(shown_weight), w(-40));
    put(0, 25);
    rd_chk("sum net", sreg(0, SUB_NET), w(-15));
  endtask : t_preset
  task automatic t_zero();
    wr(32'(OFS_CTRL), 32'h0);
    settle(0, 50);
    press(K_TARE, 0);
    press(K_ZERO, 0);
    rd_chk("zero gross", sreg(0, SUB_GROSS), w(0));
    rd_chk("tare cleared", sreg(0, SUB_NET), w(0));
    check("good zero", 32'(good_zero[0]), 32'h1);
    settle(0, 400);
    press(K_ZERO, 0);
    check("off zero", 32'(good_zero[0]), 32'h0);
    rd_chk("zero over", sreg(0, SUB_ZERO), w(50));
    settle(0, -101);
    press(K_ZERO, 0);
    rd_chk("zero under", sreg(0, SUB_ZERO), w(50));
    settle(0, -100);
    press(K_ZERO, 0);
    rd_chk("zero limit", sreg(0, SUB_ZERO), w(-100));
    wr(32'(OFS_RESOLUTION), 32'h8);
    put(0, -99);
    check("quarter in", 32'(good_zero[0]), 32'h1);
    put(0, -98);
    check("quarter out", 32'(good_zero[0]), 32'h0);
  endtask : t_zero
  task automatic t_motion();
    put(0, 500);
    wait_sig(0, 1'b0);
    press(K_TARE, 0);
    rd_chk("tare in motion", sreg(0, SUB_NET), w(0));
    wr(32'(OFS_CTRL), 32'h4);
    put(0, 800);
    press(K_TARE, 0);
    press(K_ZERO, 0);
    press(K_PRINT, 0);
    check("held", 32'(motion[0]), 32'h1);
    rd_chk("tare refused", sreg(0, SUB_NET), w(300));
    rd_chk("zero refused", sreg(0, SUB_ZERO), w(-100));
    wait_sig(0, 1'b1);
    check("print still", 32'(motion[0]), 32'h0);
    check("print scale", 32'(print_scale), 32'h0);
    settle(0, 802);
    check("at window", 32'(motion[0]), 32'h0);
    put(0, 805);
    wait_sig(0, 1'b0);
    check("past window", 32'(motion[0]), 32'h1);
  endtask : t_motion
  task automatic t_unipolar();
    wr(32'(OFS_CTRL), 32'h18);
    settle(1, -5);
    press(K_TARE, 1);
    check("negative tare", 32'(net_shown[1]), 32'h0);
    settle(1, 5);
    press(K_TARE, 1);
    check("positive tare", 32'(net_shown[1]), 32'h1);
    setpoint_armed <= 1'b1;
    repeat (2) settle(1, 1);
    rd_chk("armed", sreg(1, SUB_ZERO), w(0));
    setpoint_armed <= 1'b0;
    settle(1, 1);
    rd_chk("track", sreg(1, SUB_ZERO), w(1));
  endtask : t_unipolar
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  initial begin
    repeat (90000) @(posedge core_clk);
    errors++;
    test_done();
  end
  initial begin
    reset_n = 1'b0;
    {psel, penable, pwrite, setpoint_armed} = 4'h0;
    {paddr, pwdata} = '0;
    {keys, sel_scale, wgt} = '0;
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    t_regs();
    t_tare();
    t_preset();
    t_zero();
    t_motion();
    t_unipolar();
    test_done();
  end
endmodule : weight_tare_zero_motion_tb
